// ---- design/subsys_id_pll_ctrl_regs.sv ----
`timescale 1ns/100ps
module subsys_id_pll_ctrl_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Configuration access
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Strap pins
  input wire logic [2:0] i_strap,
  // Host PLL controls
  output logic [1:0] o_host_pll_cfg,
  output logic o_phase_reset,
  output logic o_vco_change_start
);
  wonce_if #(.W(pll_regs_pkg::VENDOR_W)) vendor_bus ();
  wonce_if #(.W(pll_regs_pkg::IDENT_W)) ident_bus ();

  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [2:0] strap_lat_q;
  logic [1:0] settle_q;
  logic strap_done_q;
  logic [1:0] cfg_q;
  logic [1:0] cfg_d;
  logic phase_q;
  logic phase_d;
  logic vco_q;
  logic vco_d;
  logic vco_start_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // Address decode
  wire hit_subsys_w = i_cfg_addr == pll_regs_pkg::OFS_SUBSYS;
  wire hit_cap_w = i_cfg_addr == pll_regs_pkg::OFS_CAP_PTR;
  wire hit_cc_w = i_cfg_addr == pll_regs_pkg::OFS_HOST_PLL_CC;
  wire wr_sub_w = i_cfg_wr & hit_subsys_w;
  wire wr_cc_lo_w = i_cfg_wr & hit_cc_w & i_cfg_be[pll_regs_pkg::LANE_CC_LO];
  wire wr_cc_hi_w = i_cfg_wr & hit_cc_w & i_cfg_be[pll_regs_pkg::LANE_CC_HI];
  wire strap_take_w = ~strap_done_q & (settle_q == pll_regs_pkg::STRAP_SETTLE);

  // Write-once fields, byte lanes merged over the current value
  wire [7:0] ven_lo_w = i_cfg_be[pll_regs_pkg::LANE_VENDOR_LO] ?
    i_cfg_wdata[7:0] : vendor_bus.value[7:0];
  wire [7:0] ven_hi_w = i_cfg_be[pll_regs_pkg::LANE_VENDOR_HI] ?
    i_cfg_wdata[15:8] : vendor_bus.value[15:8];
  assign vendor_bus.wr = wr_sub_w & (i_cfg_be[pll_regs_pkg::LANE_VENDOR_LO] |
    i_cfg_be[pll_regs_pkg::LANE_VENDOR_HI]);
  assign vendor_bus.wdata = {ven_hi_w, ven_lo_w};
  assign ident_bus.wr = wr_sub_w & i_cfg_be[pll_regs_pkg::LANE_IDENT];
  assign ident_bus.wdata = i_cfg_wdata[pll_regs_pkg::IDENT_LSB +: pll_regs_pkg::IDENT_W];

  wonce_field #(.W(pll_regs_pkg::VENDOR_W), .RST(pll_regs_pkg::VENDOR_RST)) u_vendor (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .bus(vendor_bus)
  );

  wonce_field #(.W(pll_regs_pkg::IDENT_W), .RST(pll_regs_pkg::IDENT_RST)) u_ident (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .bus(ident_bus)
  );

  // Clock control next values
  wire [1:0] cfg_wr_w = i_cfg_wdata[pll_regs_pkg::CC_CFG_LSB +: pll_regs_pkg::CC_CFG_W];
  wire phase_wr_w = i_cfg_wdata[pll_regs_pkg::CC_PHASE_BIT];
  wire vco_wr_w = i_cfg_wdata[pll_regs_pkg::CC_VCO_BIT];
  // Only a 0 to 1 change of the stored bit restarts the sequence
  wire vco_rise_w = wr_cc_hi_w & vco_wr_w & ~vco_q;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_cc_lo_w) begin
      cfg_d = cfg_wr_w;
    end else if (strap_take_w) begin
      cfg_d = strap_s2_q[1:0];
    end
  end

  assign phase_d = wr_cc_hi_w ? phase_wr_w : phase_q;
  assign vco_d = wr_cc_hi_w ? vco_wr_w : vco_q;

  // Read mux
  wire [31:0] rd_sub_w = {8'h00, ident_bus.value, vendor_bus.value};
  wire [31:0] rd_cap_w = {24'h000000, pll_regs_pkg::CAP_PTR_VAL};
  wire [31:0] rd_cc_w = {21'h000000, vco_q, phase_q, 6'h00, strap_lat_q[pll_regs_pkg::CC_STRAP_BIT],
    cfg_q};
  wire [31:0] rd_mux_w = hit_subsys_w ? rd_sub_w :
    hit_cap_w ? rd_cap_w :
    hit_cc_w ? rd_cc_w : 32'h00000000;

  // Strap synchroniser and one-time capture after reset release
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      strap_s1_q <= pll_regs_pkg::STRAP_RST;
      strap_s2_q <= pll_regs_pkg::STRAP_RST;
    end else begin
      strap_s1_q <= i_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_lat_q <= pll_regs_pkg::STRAP_RST;
    end else if (!strap_done_q) begin
      settle_q <= settle_q + 2'h1;
      if (strap_take_w) begin
        strap_done_q <= 1'b1;
        strap_lat_q <= strap_s2_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_q <= pll_regs_pkg::CC_CFG_RST;
      phase_q <= 1'b0;
      vco_q <= 1'b0;
      vco_start_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      phase_q <= phase_d;
      vco_q <= vco_d;
      vco_start_q <= vco_rise_w;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= i_cfg_rd | i_cfg_wr;
      rdata_q <= i_cfg_rd ? rd_mux_w : 32'h00000000;
    end
  end

  assign o_cfg_ack = ack_q;
  assign o_cfg_rdata = rdata_q;
  assign o_host_pll_cfg = cfg_q;
  assign o_phase_reset = phase_q;
  assign o_vco_change_start = vco_start_q;

  vendor_locked_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vendor_bus.locked && wr_sub_w |=> vendor_bus.value == $past(vendor_bus.value))
    else $error("vendor field written after lock");
  vendor_reset_a: assert property (@(posedge i_clk)
    !i_rstn |=> vendor_bus.value == pll_regs_pkg::VENDOR_RST)
    else $error("vendor field not zero after reset");
  vendor_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg_rd && hit_subsys_w |=>
      o_cfg_rdata[pll_regs_pkg::VENDOR_W-1:0] == $past(vendor_bus.value))
    else $error("vendor field read back wrong");
  ident_locked_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ident_bus.locked && ident_bus.wr |=> ident_bus.value == $past(ident_bus.value))
    else $error("ident field written after lock");
  ident_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg_rd && hit_subsys_w |=>
      o_cfg_rdata[pll_regs_pkg::IDENT_LSB +: pll_regs_pkg::IDENT_W] == $past(ident_bus.value))
    else $error("ident field read back wrong");
  cap_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg_rd && hit_cap_w |=> o_cfg_ack && o_cfg_rdata == 32'h00000000)
    else $error("capability pointer not zero");
  phase_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_cc_hi_w |=> o_phase_reset == $past(phase_wr_w))
    else $error("phase reset does not follow bit 9");
  phase_reset_a: assert property (@(posedge i_clk)
    !i_rstn |=> !o_phase_reset)
    else $error("phase reset active after reset");
  phase_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !wr_cc_hi_w |=> $stable(o_phase_reset))
    else $error("phase reset changed without a write");
  cfg_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_cc_lo_w |=> o_host_pll_cfg == $past(cfg_wr_w))
    else $error("clock configuration write lost");
  cfg_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !wr_cc_lo_w && !strap_take_w |=> $stable(o_host_pll_cfg))
    else $error("clock configuration changed without a write");
  strap_show_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    strap_take_w && !wr_cc_lo_w |=> o_host_pll_cfg == $past(strap_s2_q[1:0]))
    else $error("strap pattern not reported");
  strap_keep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    strap_done_q |=> $stable(strap_lat_q))
    else $error("captured strap pattern changed");
  cc_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg_rd && hit_cc_w |=> o_cfg_rdata[pll_regs_pkg::CC_STRAP_BIT] ==
      $past(strap_lat_q[pll_regs_pkg::CC_STRAP_BIT]))
    else $error("strap bit not reported in clock control");
  vco_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_vco_change_start |-> vco_q && !$past(vco_q) ##1 !o_vco_change_start)
    else $error("VCO start pulse without clear-then-set");
  vco_start_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_cc_hi_w && vco_wr_w && !vco_q |=> o_vco_change_start)
    else $error("VCO start pulse missing after clear-then-set");
  vco_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !wr_cc_hi_w |=> !o_vco_change_start)
    else $error("VCO start pulse without a write");

  vendor_lock_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    vendor_bus.wr && !vendor_bus.locked ##[1:8] vendor_bus.wr && vendor_bus.locked);
  vco_restart_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    o_vco_change_start ##[1:20] o_vco_change_start);
  strap_high_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    strap_take_w && strap_s2_q == pll_regs_pkg::STRAP_MEM333_CORE250);
  strap_low_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    strap_take_w && strap_s2_q == pll_regs_pkg::STRAP_MEM266_CORE200);
endmodule

// ---- common/pll_regs_pkg.sv ----
package pll_regs_pkg;
  // Configuration offsets, dword aligned byte addresses
  localparam logic [7:0] OFS_SUBSYS = 8'h2c;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_HOST_PLL_CC = 8'hc0;
  // Byte lanes inside the subsystem dword
  localparam int LANE_VENDOR_LO = 0;
  localparam int LANE_VENDOR_HI = 1;
  localparam int LANE_IDENT = 2;
  // Byte lanes inside the clock control dword
  localparam int LANE_CC_LO = 0;
  localparam int LANE_CC_HI = 1;
  // Field layout
  localparam int VENDOR_W = 16;
  localparam int IDENT_W = 8;
  localparam int IDENT_LSB = 16;
  localparam int CC_CFG_LSB = 0;
  localparam int CC_CFG_W = 2;
  localparam int CC_STRAP_BIT = 2;
  localparam int CC_PHASE_BIT = 9;
  localparam int CC_VCO_BIT = 10;
  localparam int STRAP_W = 3;
  // Reset values
  localparam logic [15:0] VENDOR_RST = 16'h0000;
  localparam logic [7:0] IDENT_RST = 8'h00;
  localparam logic [7:0] CAP_PTR_VAL = 8'h00;
  localparam logic [1:0] CC_CFG_RST = 2'h0;
  localparam logic [2:0] STRAP_RST = 3'h0;
  // Strap patterns: 266 MHz memory / 200 MHz core, 333 MHz memory / 250 MHz core
  localparam logic [2:0] STRAP_MEM266_CORE200 = 3'h0;
  localparam logic [2:0] STRAP_MEM333_CORE250 = 3'h7;
  // Cycles after reset release before the synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// ---- common/wonce_if.sv ----
`timescale 1ns/100ps
interface wonce_if #(parameter int W = 8);
  logic wr;
  logic [W-1:0] wdata;
  logic [W-1:0] value;
  logic locked;
  modport field (input wr, input wdata, output value, output locked);
  modport user (output wr, output wdata, input value, input locked);
endinterface

// ---- design/wonce_field.sv ----
`timescale 1ns/100ps
module wonce_field #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Field access
  wonce_if.field bus
);
  logic [W-1:0] value_q;
  logic locked_q;
  wire take_w = bus.wr & ~locked_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      value_q <= RST;
      locked_q <= 1'b0;
    end else if (take_w) begin
      value_q <= bus.wdata;
      locked_q <= 1'b1;
    end
  end

  assign bus.value = value_q;
  assign bus.locked = locked_q;

  field_frozen_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    locked_q |=> value_q == $past(value_q))
    else $error("write-once field changed after lock");
  relock_reset_a: assert property (@(posedge i_clk)
    !i_rstn |=> !locked_q && value_q == RST)
    else $error("reset did not reopen write-once field");
  first_take_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    bus.wr && !locked_q |=> locked_q && value_q == $past(bus.wdata))
    else $error("first write not taken");
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic i_clk, i_rstn, i_cfg_rd, i_cfg_wr;
  logic [7:0] i_cfg_addr;
  logic [3:0] i_cfg_be;
  logic [31:0] i_cfg_wdata;
  logic [2:0] i_strap;
  logic o_cfg_ack, o_phase_reset, o_vco_change_start;
  logic [31:0] o_cfg_rdata;
  logic [1:0] o_host_pll_cfg;
  logic [4:0] ctl;
  int n_fail, checked, cycles;
  // Reference model state
  logic [15:0] vend;
  logic [7:0] idn;
  logic [15:0] cc;
  bit vlock, ilock;

  subsys_id_pll_ctrl_regs dut_u (
    .i_clk, .i_rstn, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata,
    .o_cfg_ack, .o_cfg_rdata, .i_strap, .o_host_pll_cfg, .o_phase_reset,
    .o_vco_change_start
  );

  assign ctl = {o_cfg_ack, o_vco_change_start, o_phase_reset, o_host_pll_cfg};

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic conclude();
    $display("Counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: read data %h, expected %h", $time, got, exp);
    end
  endtask

  // Order: ack, start pulse, phase reset, clock config
  task automatic chk_ctl(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: controls %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(negedge i_clk);
    i_rstn = 1'b0;
    i_strap = s;
    repeat (12) @(negedge i_clk);
    chk_ctl(ctl, 5'h00);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    vend = 16'h0000;
    idn = 8'h00;
    vlock = 1'b0;
    ilock = 1'b0;
    cc = {13'h0000, s};
  endtask

  task automatic acc(input bit wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    logic pulse;
    logic [31:0] exp;
    @(negedge i_clk);
    i_cfg_rd = !wr;
    i_cfg_wr = wr;
    i_cfg_addr = a;
    i_cfg_be = be;
    i_cfg_wdata = d;
    @(negedge i_clk);
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg_wdata = ~d;
    exp = 32'h0;
    pulse = 1'b0;
    if (!wr && a == 8'h2c) exp = {8'h00, idn, vend};
    if (!wr && a == 8'hc0) exp = {16'h0000, cc};
    if (wr && a == 8'h2c && !vlock && (be[0] || be[1])) begin
      if (be[0]) vend[7:0] = d[7:0];
      if (be[1]) vend[15:8] = d[15:8];
      vlock = 1'b1;
    end
    if (wr && a == 8'h2c && !ilock && be[2]) begin
      idn = d[23:16];
      ilock = 1'b1;
    end
    if (wr && a == 8'hc0 && be[0]) cc[1:0] = d[1:0];
    if (wr && a == 8'hc0 && be[1]) begin
      pulse = d[10] && !cc[10];
      cc[10:9] = d[10:9];
    end
    chk_data(o_cfg_rdata, exp);
    chk_ctl(ctl, {1'b1, pulse, cc[9], cc[1:0]});
  endtask

  initial begin
    logic [2:0] s;
    logic [31:0] v;
    i_rstn = 1'b0;
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg_addr = 8'h00;
    i_cfg_be = 4'h0;
    i_cfg_wdata = 32'h0;
    i_strap = 3'h0;
    v = $urandom(32'hdc28f772);
    for (int k = 0; k < 3; k++) begin
      s = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom);
      do_reset(s);
      acc(1'b0, 8'hc0, 4'h0, 32'h0);
      acc(1'b0, 8'h2c, 4'h0, 32'h0);
      acc(1'b0, 8'h48, 4'h0, 32'h0);
      v = $urandom;
      acc(1'b1, 8'h2c, 4'h1, v);
      acc(1'b1, 8'h2c, 4'h2, ~v);
      acc(1'b1, 8'h2c, 4'h4, v);
      acc(1'b1, 8'h2c, 4'hf, ~v);
      acc(1'b0, 8'h2c, 4'h0, 32'h0);
      acc(1'b1, 8'h34, 4'hf, 32'hffffffff);
      acc(1'b0, 8'h34, 4'h0, 32'h0);
      v = $urandom;
      acc(1'b1, 8'hc0, 4'h3, v | 32'h400);
      acc(1'b1, 8'hc0, 4'h2, v | 32'h400);
      acc(1'b1, 8'hc0, 4'h3, ~v & 32'hfffffbff);
      acc(1'b1, 8'hc0, 4'h2, 32'h600);
      acc(1'b0, 8'hc0, 4'h0, 32'h0);
      $display("Test with strap %b done", s);
    end
    conclude();
  end
endmodule
